/* File: rtl/fbcws_sequencer.v */
`timescale 1ns/1ns
`include "fbcws_defs.vh"
module fbcws_sequencer (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Fieldbus command word port
   input wire [15:0] cmd_in,
   input wire cmd_wr,
   // Configuration
   input wire start_mode,
   input wire fb_active,
   input wire app_precharge,
   input wire qstop_fault_en,
   // Plant feedback
   input wire fault_active,
   input wire wdog_fault,
   input wire dc_charged,
   input wire breaker_closed,
   input wire ready_to_run,
   // Plant commands
   output reg precharge_on,
   output reg main_breaker_close,
   output reg modulate,
   output reg quick_stop,
   output reg qstop_exception,
   output reg event_reset,
   // Status
   output reg [1:0] profile_state,
   output reg [15:0] status_word,
   output wire [15:0] cmd_word
);
   // ****************************************
   // Command word capture
   // ****************************************
   wire start_rise;
   wire reset_rise;
   wire fb_cmd;
   wire sw_on;
   wire brk_ok;
   wire qstop_n;
   wire start_bit;
   wire start_ok;
   wire stop_cond;
   reg start_armed;
   reg [1:0] next_state;

   // ****************************************
   // Helpers
   // ****************************************
   function is_state(input [1:0] state, input [1:0] want);
      begin
         is_state = (state == want);
      end
   endfunction

   fbcws_cmd_latch u_latch (
      .clk(clk),
      .rst_n(rst_n),
      .cmd_in(cmd_in),
      .cmd_wr(cmd_wr),
      .wdog_fault(wdog_fault),
      .cmd_word(cmd_word)
   );

   fbcws_edge u_start_edge (
      .clk(clk),
      .rst_n(rst_n),
      .level(cmd_word[`FBCWS_CW_START]),
      .rise(start_rise)
   );

   fbcws_edge u_reset_edge (
      .clk(clk),
      .rst_n(rst_n),
      .level(cmd_word[`FBCWS_CW_EVRST]),
      .rise(reset_rise)
   );

   // Outside the fieldbus place every command bit reads as inactive
   assign fb_cmd = fb_active;
   assign sw_on = fb_cmd & cmd_word[`FBCWS_CW_SWON];
   assign brk_ok = fb_cmd & cmd_word[`FBCWS_CW_BRK];
   assign qstop_n = ~fb_cmd | cmd_word[`FBCWS_CW_QSTOP_N];
   assign start_bit = fb_cmd & cmd_word[`FBCWS_CW_START];

   // ****************************************
   // Start request qualification
   // ****************************************
   // Edge mode arms on a rise and disarms when bit 3 falls or a fault
   // appears, so a fault clear with bit 3 still high will not restart.
   // A start is used up once switched on, so a restored interlock needs a new rise.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_armed <= 1'b0;
      end else begin
         if (!start_bit || fault_active) begin
            start_armed <= 1'b0;
         end else if (start_rise) begin
            start_armed <= 1'b1;
         end else if (is_state(profile_state, `FBCWS_ST_ON)) begin
            start_armed <= 1'b0;
         end
      end
   end

   // Level mode needs only the high state, so fault clear restarts
   assign start_ok = (start_mode == `FBCWS_MODE_EDGE) ? (start_armed & start_bit) :
                     start_bit;
   assign stop_cond = ~start_bit | ~sw_on | ~brk_ok | ~qstop_n |
                      fault_active;

   // ****************************************
   // Profile state machine
   // ****************************************
   always @* begin
      next_state = profile_state;
      case (profile_state)
         `FBCWS_ST_OFF: begin
            if (sw_on && qstop_n && !fault_active) begin
               next_state = `FBCWS_ST_READY;
            end
         end
         `FBCWS_ST_READY: begin
            if (!sw_on || fault_active) begin
               next_state = `FBCWS_ST_OFF;
            end else if (start_ok && brk_ok && qstop_n && dc_charged) begin
               next_state = `FBCWS_ST_ON;
            end
         end
         `FBCWS_ST_ON: begin
            if (!sw_on || fault_active) begin
               next_state = `FBCWS_ST_OFF;
            end else if (stop_cond) begin
               next_state = `FBCWS_ST_READY;
            end else if (breaker_closed && ready_to_run) begin
               next_state = `FBCWS_ST_OPER;
            end
         end
         default: begin
            if (!sw_on || fault_active) begin
               next_state = `FBCWS_ST_OFF;
            end else if (stop_cond) begin
               next_state = `FBCWS_ST_READY;
            end
         end
      endcase
      // Advance only under fieldbus control with valid data
      if (!(fb_active && cmd_word[`FBCWS_CW_VALID]) &&
          next_state > profile_state) begin
         next_state = profile_state;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         profile_state <= `FBCWS_ST_OFF;
      end else begin
         profile_state <= next_state;
      end
   end

   // ****************************************
   // Plant commands
   // ****************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         precharge_on <= 1'b0;
         main_breaker_close <= 1'b0;
         modulate <= 1'b0;
         quick_stop <= 1'b0;
         qstop_exception <= 1'b0;
         event_reset <= 1'b0;
      end else begin
         // Charge per command bit 4 with app_precharge, else while a start is pending in READY and the link is not yet charged
         if (!sw_on || fault_active) begin
            precharge_on <= 1'b0;
         end else if (app_precharge) begin
            precharge_on <= cmd_word[`FBCWS_CW_PRECHG] & fb_cmd;
         end else begin
            precharge_on <= (profile_state == `FBCWS_ST_READY) & start_ok &
                            ~dc_charged;
         end
         // Breaker closes only after charge and with permission
         main_breaker_close <= sw_on & brk_ok & ~stop_cond & dc_charged &
                               (next_state[1]);
         modulate <= (next_state == `FBCWS_ST_OPER);
         quick_stop <= ~qstop_n & is_state(profile_state, `FBCWS_ST_OPER);
         qstop_exception <= ~qstop_n & qstop_fault_en &
                            is_state(profile_state, `FBCWS_ST_OPER);
         // Reset request passes independent of start logic
         event_reset <= reset_rise & fb_cmd;
      end
   end

   // ****************************************
   // Status word
   // ****************************************
   // Built from plant state and the fieldbus-gated command bits, updated every cycle so it stays live
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_word <= 16'h0000;
      end else begin
         status_word <= 16'h0000;
         status_word[`FBCWS_SW_RDY_ON] <= sw_on & qstop_n & ~fault_active;
         status_word[`FBCWS_SW_RDY_RUN] <= ready_to_run;
         status_word[`FBCWS_SW_RUN] <= modulate;
         status_word[`FBCWS_SW_FAULT] <= fault_active;
         status_word[`FBCWS_SW_QSTOP_N] <= qstop_n;
         status_word[7:6] <= profile_state;
      end
   end
endmodule

/* File: rtl/fbcws_defs.vh */
`ifndef FBCWS_DEFS_VH
`define FBCWS_DEFS_VH
// Command word bit positions
`define FBCWS_CW_SWON 0
`define FBCWS_CW_BRK 1
`define FBCWS_CW_QSTOP_N 2
`define FBCWS_CW_START 3
`define FBCWS_CW_PRECHG 4
`define FBCWS_CW_EVRST 7
`define FBCWS_CW_VALID 10
`define FBCWS_CW_WDOG 11
// Default command word
`define FBCWS_CW_DEFAULT 16'h0005
// Start modes
`define FBCWS_MODE_LEVEL 1'b0
`define FBCWS_MODE_EDGE 1'b1
// Profile states
`define FBCWS_ST_OFF 2'h0
`define FBCWS_ST_READY 2'h1
`define FBCWS_ST_ON 2'h2
`define FBCWS_ST_OPER 2'h3
// Status word bit positions
`define FBCWS_SW_RDY_ON 0
`define FBCWS_SW_RDY_RUN 1
`define FBCWS_SW_RUN 2
`define FBCWS_SW_FAULT 3
`define FBCWS_SW_QSTOP_N 5
`endif

/* File: rtl/fbcws_cmd_latch.v */
`timescale 1ns/1ns
`include "fbcws_defs.vh"
module fbcws_cmd_latch (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Incoming word
   input wire [15:0] cmd_in,
   input wire cmd_wr,
   input wire wdog_fault,
   // Accepted word
   output reg [15:0] cmd_word
);
   // ****************************************
   // Word acceptance
   // ****************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_word <= `FBCWS_CW_DEFAULT;
      end else if (wdog_fault) begin
         cmd_word <= `FBCWS_CW_DEFAULT;
      end else if (cmd_wr) begin
         if (cmd_in[`FBCWS_CW_VALID]) begin
            cmd_word <= cmd_in;
         end else begin
            // Hold old data, but valid and watchdog always follow
            cmd_word[`FBCWS_CW_VALID] <= 1'b0;
            cmd_word[`FBCWS_CW_WDOG] <= cmd_in[`FBCWS_CW_WDOG];
         end
      end
   end
endmodule

/* File: rtl/fbcws_edge.v */
`timescale 1ns/1ns
module fbcws_edge (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Level in, rise out
   input wire level,
   output wire rise
);
   reg prev;
   // ****************************************
   // Previous value
   // ****************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 1'b0;
      end else begin
         prev <= level;
      end
   end
   assign rise = level & ~prev;
endmodule

/* File: sim/fbcws_chk.sv */
`timescale 1ns/1ns
`include "fbcws_defs.vh"
module fbcws_chk (
   // Clock and reset
   input logic clk,
   input logic rst_n,
   // Command side
   input logic [15:0] cmd_in,
   input logic cmd_wr,
   input logic fb_active,
   input logic wdog_fault,
   input logic [15:0] cmd_word,
   // Plant and status
   input logic precharge_on,
   input logic main_breaker_close,
   input logic modulate,
   input logic event_reset,
   input logic [1:0] profile_state,
   input logic [15:0] status_word
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ****
   // Sequences
   // ****
   sequence s_halted;
      ##[1:3] !modulate;
   endsequence
   sequence s_closing;
      main_breaker_close && profile_state == `FBCWS_ST_ON;
   endsequence
   // ****
   // Properties
   // ****
   property p_stop;
      $fell(cmd_word[3]) |-> s_halted;
   endproperty
   property p_qstop;
      !cmd_word[2] |-> s_halted;
   endproperty
   property p_swon;
      !cmd_word[0] |-> ##[1:3] !precharge_on && !main_breaker_close && !modulate;
   endproperty
   property p_brk;
      !cmd_word[1] |-> ##[1:3] !main_breaker_close && !modulate;
   endproperty
   property p_gate;
      $rose(modulate) |-> $past(main_breaker_close) && cmd_word[1:0] == 2'h3;
   endproperty
   property p_order;
      $rose(main_breaker_close) |-> s_closing;
   endproperty
   // Falling is allowed, advancing is not
   property p_adv;
      !fb_active || !cmd_word[10] |=> profile_state <= $past(profile_state);
   endproperty
   property p_wdog;
      wdog_fault |=> cmd_word == `FBCWS_CW_DEFAULT;
   endproperty
   property p_hold;
      cmd_wr && !cmd_in[10] && !wdog_fault |=> cmd_word[9:0] == $past(cmd_word[9:0]);
   endproperty
   property p_ev;
      event_reset |=> !event_reset;
   endproperty
   property p_stat;
      status_word[7:6] == $past(profile_state) && status_word[2] == $past(modulate);
   endproperty
   a_stop: assert property (p_stop) else $error("run kept after start bit fell");
   a_qstop: assert property (p_qstop) else $error("run kept in quick stop");
   a_swon: assert property (p_swon) else $error("switch-on interlock ignored");
   a_brk: assert property (p_brk) else $error("breaker interlock ignored");
   a_gate: assert property (p_gate) else $error("run without closed breaker");
   a_order: assert property (p_order) else $error("breaker closed out of order");
   a_adv: assert property (p_adv) else $error("state advanced while refused");
   a_wdog: assert property (p_wdog) else $error("default word not applied");
   a_hold: assert property (p_hold) else $error("invalid word changed data");
   a_ev: assert property (p_ev) else $error("event reset too long");
   a_stat: assert property (p_stat) else $error("status word stale");
endmodule
bind fbcws_sequencer fbcws_chk fbcws_chk_i (.*);

/* File: sim/fbcws_master.sv */
`timescale 1ns/1ns
module fbcws_master (
   // Clock
   input logic clk,
   // Bench requests
   input logic go,
   input logic [15:0] word,
   // Command word port
   output logic [15:0] cmd_in,
   output logic cmd_wr
);
   initial begin
      cmd_in = 16'h0000;
      cmd_wr = 1'b0;
   end
   // Idle data toggles so a stale word is never read as valid
   always @(posedge clk) begin
      cmd_wr <= #1 go;
      cmd_in <= #1 go ? (word & 16'hff9f) : ~cmd_in;
   end
endmodule

/* File: sim/fieldbus_command_word_sequencer_test.sv */
`timescale 1ns/1ns
`include "fbcws_defs.vh"
module fieldbus_command_word_sequencer_test;
   logic clk = 0, rst_n = 0, go = 0, cmd_wr, start_mode = 0, fb_active = 1;
   logic fault_active = 0, wdog_fault = 0, dc_charged = 0, precharge_on, main_breaker_close;
   logic app_precharge = 0, qstop_fault_en = 1;
   logic modulate, quick_stop, qstop_exception, event_reset;
   logic [15:0] word = 16'h0000, cmd_in, status_word, cmd_word;
   logic [1:0] profile_state;
   int mismatches = 0, comparisons = 0, events = 0;
   always #20 clk = ~clk;
   // Plant: link stays charged once charged, simple but optimistic for restarts
   always @(posedge clk) dc_charged <= #1 dc_charged | precharge_on;
   always @(posedge clk) if (event_reset === 1'b1) events++;
   fbcws_master fbcws_master_i (.clk(clk), .go(go), .word(word), .cmd_in(cmd_in), .cmd_wr(cmd_wr));
   fbcws_sequencer fbcws_sequencer_i (.*, .breaker_closed(main_breaker_close),
      .ready_to_run(1'b1));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] w);
      word = w;
      go = 1;
      cyc(1);
      go = 0;
      cyc(2);
   endtask
   task automatic run(input logic e);
      int n;
      n = 0;
      while (modulate !== e && n < 20) begin
         cyc(1);
         n++;
      end
      chk("modulate", {15'h0, e}, {15'h0, modulate});
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      stop_test;
   end
   initial begin
      cyc(5);
      rst_n = 1;
      chk("cmd_word", `FBCWS_CW_DEFAULT, cmd_word);
      wr(16'h040f);
      run(1);
      chk("state", {14'h0, `FBCWS_ST_OPER}, {14'h0, profile_state});
      cyc(1);
      chk("status", 16'h00e7, status_word);
      wr(16'h048f);
      cyc(2);
      chk("events", 16'h0001, events[15:0]);
      wr(16'h0000);
      chk("cmd_word", 16'h008f, cmd_word);
      // Each interlock and the start bit: drop while running, then block a start
      for (int i = 0; i < 4; i++) begin
         wr(16'h0407);
         wr(16'h040f);
         run(1);
         wr(16'h040f ^ (16'h0001 << i));
         chk("quick_stop", {15'h0, i == 2}, {15'h0, quick_stop});
         chk("qstop_exception", {15'h0, i == 2}, {15'h0, qstop_exception});
         run(0);
         chk("main_breaker_close", 16'h0000, {15'h0, main_breaker_close});
         wr(16'h0407);
         wr(16'h040f ^ (16'h0001 << i));
         cyc(8);
         chk("blocked", 16'h0000, {15'h0, modulate});
      end
      // Quick stop with the exception switched off, then application precharge
      qstop_fault_en = 0;
      wr(16'h040f);
      run(1);
      wr(16'h040b);
      chk("quick_stop", 16'h0001, {15'h0, quick_stop});
      chk("qstop_exception", 16'h0000, {15'h0, qstop_exception});
      qstop_fault_en = 1;
      app_precharge = 1;
      wr(16'h0417);
      chk("precharge_on", 16'h0001, {15'h0, precharge_on});
      wr(16'h0407);
      chk("precharge_on", 16'h0000, {15'h0, precharge_on});
      app_precharge = 0;
      for (int m = 0; m < 2; m++) begin
         start_mode = m[0];
         wr(16'h0407);
         wr(16'h040f);
         run(1);
         fault_active = 1;
         run(0);
         fault_active = 0;
         cyc(10);
         chk("restart", {15'h0, ~m[0]}, {15'h0, modulate});
      end
      wr(16'h0407);
      wr(16'h040f);
      run(1);
      // Edge mode: interlock dropped and restored with bit 3 held high, no restart
      wr(16'h040e);
      run(0);
      wr(16'h040f);
      cyc(8);
      chk("edge restart", 16'h0000, {15'h0, modulate});
      fb_active = 0;
      cyc(6);
      chk("state", {14'h0, `FBCWS_ST_OFF}, {14'h0, profile_state});
      chk("status", 16'h0022, status_word);
      fb_active = 1;
      wdog_fault = 1;
      cyc(2);
      chk("cmd_word", `FBCWS_CW_DEFAULT, cmd_word);
      wdog_fault = 0;
      stop_test;
   end
endmodule
